// >>> hw/ckdcfg_word.sv
// configuration word holder and field decoder
`timescale 1ns/100ps
module ckdcfg_word (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic cfg_wr,
   input wire logic [95:0] cfg_wdata,
   input wire logic restore_valid,
   input wire logic [95:0] restore_data,
   input wire logic store_req,
   output logic [95:0] cfg_rdata,
   output logic store_go,
   output logic store_refused,
   output ckdcfg_pkg::ckd_cfg_s cfg
);
   import ckdcfg_pkg::*;

   logic [95:0] word_q;
   logic [95:0] word_d;
   logic store_go_q;
   logic store_ref_q;
   ckd_cfg_s cfg_q;
   ckd_cfg_s cfg_d;

   function automatic ckd_skew_s skew_dec(input logic [4:0] c);
      ckd_skew_s s;
      s.units = 3'h0;
      s.mode = CKD_SK_RSVD;
      if (c == 5'h00) begin
         s.mode = CKD_SK_ZERO;
      end else if (c[4:3] == 2'h0) begin
         s.mode = CKD_SK_LEAD;
         s.units = 3'(4'h8 - {1'b0, c[2:0]});
      end else if (c[4:3] == 2'h1 && c[2:0] != 3'h0) begin
         s.mode = CKD_SK_LAG;
         s.units = c[2:0];
      end else if (c == 5'h10) begin
         s.mode = CKD_SK_INV;
      end else if (c == 5'h11) begin
         s.mode = CKD_SK_DIV2;
      end else if (c == 5'h12) begin
         s.mode = CKD_SK_DIV4;
      end
      return s;
   endfunction

   function automatic ckd_in_e in_dec(input logic [1:0] c);
      case (c)
         2'h0: in_dec = CKD_IN_DIFF;
         2'h1: in_dec = CKD_IN_25;
         2'h3: in_dec = CKD_IN_18;
         default: in_dec = CKD_IN_RSVD;
      endcase
   endfunction

   function automatic ckd_drv_e drv_dec(input logic [1:0] c);
      case (c)
         2'h0: drv_dec = CKD_DRV_25;
         2'h1: drv_dec = CKD_DRV_18;
         2'h2: drv_dec = CKD_DRV_HSTL;
         default: drv_dec = CKD_DRV_RSVD;
      endcase
   endfunction

   // restore wins over host write; reserved bits forced to zero
   always_comb begin
      word_d = word_q;
      if (restore_valid) begin
         word_d = restore_data & ~CKD_RSVD_MASK;
      end else if (cfg_wr) begin
         word_d = cfg_wdata & ~CKD_RSVD_MASK;
      end
   end

   always_comb begin
      cfg_d = cfg_q;
      cfg_d.ctrl_pins_25v = word_d[CKD_CTRL_LVL_BIT];
      cfg_d.vco_high_range = word_d[CKD_VCO_RANGE_BIT];
      cfg_d.rising_edge = word_d[CKD_EDGE_BIT];
      cfg_d.pll_bypass = word_d[CKD_PLL_BYP_BIT];
      cfg_d.gated_style = word_d[CKD_DIS_STYLE_BIT];
      cfg_d.fb_divide = word_d[CKD_FBDIV_LSB +: 4];
      for (int i = 0; i < 3; i++) begin
         cfg_d.in_sel[2 - i] = in_dec(word_d[CKD_INSEL_LSB + 4 - 2 * i +: 2]);
      end
      for (int i = 0; i < 6; i++) begin
         cfg_d.drive[5 - i] = drv_dec(word_d[CKD_DRIVE_LSB + 10 - 2 * i +: 2]);
         cfg_d.skew[5 - i] = skew_dec(word_d[CKD_SKEW_LSB + 25 - 5 * i +: 5]);
      end
      for (int i = 0; i < 5; i++) begin
         if (!word_d[CKD_BANK_EN_LSB + 4 - i]) begin
            cfg_d.bank_state[4 - i] = CKD_OUT_RUN;
         end else if (word_d[CKD_DIS_STYLE_BIT]) begin
            cfg_d.bank_state[4 - i] = CKD_OUT_GATED;
         end else begin
            cfg_d.bank_state[4 - i] = CKD_OUT_TRI;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         word_q <= CKD_WORD_RST;
      end else if (clk_en) begin
         word_q <= word_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cfg_q <= '0;
      end else if (clk_en) begin
         cfg_q <= cfg_d;
      end
   end

   // storage only proceeds while the PLL runs
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         store_go_q <= 1'b0;
         store_ref_q <= 1'b0;
      end else if (clk_en) begin
         store_go_q <= store_req && !word_q[CKD_PLL_BYP_BIT];
         store_ref_q <= store_req && word_q[CKD_PLL_BYP_BIT];
      end
   end

   assign cfg_rdata = word_q;
   assign store_go = store_go_q;
   assign store_refused = store_ref_q;
   assign cfg = cfg_q;
endmodule

// >>> hw/ckdcfg_pkg.sv
// constants, types and field layout of the clock driver configuration word
// Operation
// - bit 61 picks control pin level: one 2.5 V, zero 1.8 V
// - bit 60 picks oscillator range: zero low range, one high range
// - bit 58 picks reference edge: zero falling, one rising
// - bit 57 copies the PLL enable pin meaning
// - storage timing follows PLL; device refuses storage while PLL bypassed
// - bit 59 copies the disable-style pin meaning
// - bits 56 to 52 are bank 1 to 5 output enables
// - banks 1 to 5 have two-bit drive selects at 47:46 down to 39:38
// - feedback bank drive select sits at bits 37:36
// - input selects at 35:34, 33:32, 31:30 for references and feedback
// - bank 1 skew code at bits 29 down to 25
// - bank 2 skew code starts at bit 24 downward
// - input code: 00 differential, 01 2.5 V, 11 1.8 V, else reserved
// - drive code: 00 2.5 V, 01 1.8 V, 10 HSTL, else reserved
// - enable one disables bank: tri-state or gated by disable style
package ckdcfg_pkg;
   localparam int CKD_WORD_W = 96;
   localparam logic [95:0] CKD_WORD_RST = 96'h0;
   localparam logic [95:0] CKD_RSVD_MASK = 96'hFFFFFFFF_C0000000_00000000;
   localparam int CKD_CTRL_LVL_BIT = 61;
   localparam int CKD_VCO_RANGE_BIT = 60;
   localparam int CKD_DIS_STYLE_BIT = 59;
   localparam int CKD_EDGE_BIT = 58;
   localparam int CKD_PLL_BYP_BIT = 57;
   localparam int CKD_BANK_EN_LSB = 52;
   localparam int CKD_FBDIV_LSB = 48;
   localparam int CKD_DRIVE_LSB = 36;
   localparam int CKD_INSEL_LSB = 30;
   localparam int CKD_SKEW_LSB = 0;

   typedef enum logic [1:0] {CKD_IN_DIFF, CKD_IN_25, CKD_IN_18, CKD_IN_RSVD} ckd_in_e;
   typedef enum logic [1:0] {CKD_DRV_25, CKD_DRV_18, CKD_DRV_HSTL, CKD_DRV_RSVD} ckd_drv_e;
   typedef enum logic [1:0] {CKD_OUT_RUN, CKD_OUT_TRI, CKD_OUT_GATED} ckd_out_e;
   typedef enum logic [2:0] {CKD_SK_ZERO, CKD_SK_LEAD, CKD_SK_LAG, CKD_SK_INV,
      CKD_SK_DIV2, CKD_SK_DIV4, CKD_SK_RSVD} ckd_skmode_e;

   typedef struct packed {
      ckd_skmode_e mode;
      logic [2:0] units;
   } ckd_skew_s;

   typedef struct packed {
      logic ctrl_pins_25v;
      logic vco_high_range;
      logic rising_edge;
      logic pll_bypass;
      logic gated_style;
      logic [3:0] fb_divide;
      ckd_in_e [2:0] in_sel;
      ckd_drv_e [5:0] drive;
      ckd_out_e [4:0] bank_state;
      ckd_skew_s [5:0] skew;
   } ckd_cfg_s;
endpackage

// >>> verification/ckdcfg_host.sv
// programming host model: whole-word writes and store requests
`timescale 1ns/100ps
module ckdcfg_host (
   input wire logic ref_clk,
   output logic cfg_wr = 0,
   output logic [95:0] cfg_wdata = '0,
   output logic store_req = 0
);
   task automatic write(input logic [95:0] w);
      cfg_wdata = w & ~ckdcfg_pkg::CKD_RSVD_MASK;
      cfg_wr = 1;
      @(negedge ref_clk) cfg_wr = 0;
   endtask
   task automatic save();
      store_req = 1;
      @(negedge ref_clk) store_req = 0;
   endtask
endmodule

// >>> verification/ckdcfg_properties.sv
// assertions on the configuration word ports
`timescale 1ns/100ps
module ckdcfg_properties (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic cfg_wr,
   input wire logic [95:0] cfg_wdata,
   input wire logic restore_valid,
   input wire logic store_req,
   input wire logic [95:0] cfg_rdata,
   input wire logic store_go,
   input wire logic store_refused,
   input wire ckdcfg_pkg::ckd_cfg_s cfg
);
   import ckdcfg_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_st; clk_en && store_req; endsequence
   AST_WRITE: assert property (clk_en && cfg_wr && !restore_valid |=>
      cfg_rdata == ($past(cfg_wdata) & ~CKD_RSVD_MASK)) else $error("write lost");
   AST_HOLD: assert property (!(clk_en && (cfg_wr || restore_valid)) |=>
      $stable(cfg_rdata)) else $error("word moved");
   AST_FLAGS: assert property (cfg_rdata[61:57] == {cfg.ctrl_pins_25v,
      cfg.vco_high_range, cfg.gated_style, cfg.rising_edge, cfg.pll_bypass}) else $error("flags");
   AST_BANK: assert property (cfg.bank_state[4] == (cfg_rdata[56] ? 1 + cfg_rdata[59] : 0))
      else $error("bank state");
   AST_SKEW: assert property (cfg_rdata[29:25] == 5'h10 |-> cfg.skew[5].mode == CKD_SK_INV)
      else $error("skew decode");
   AST_GO: assert property (s_st ##0 !cfg_rdata[57] |=> store_go && !store_refused)
      else $error("store not started");
   AST_REFUSE: assert property (s_st ##0 cfg_rdata[57] |=> store_refused && !store_go)
      else $error("store not refused");
   AST_QUIET: assert property (!(clk_en && store_req) |=> !store_go && !store_refused)
      else $error("stray store pulse");
endmodule

// >>> verification/testbench.sv
// self-checking bench for the configuration word block
`timescale 1ns/100ps
module testbench;
   import ckdcfg_pkg::*;
   logic ref_clk = 0, resetn = 0, clk_en = 1, restore_valid = 0;
   logic cfg_wr, store_req, store_go, store_refused;
   logic [95:0] cfg_wdata, restore_data = '0, cfg_rdata, w, exp_w = '0;
   ckd_cfg_s cfg;
   int err_count, total_checks, cyc;
   int skm[32] = '{0, 1, 1, 1, 1, 1, 1, 1, 6, 2, 2, 2, 2, 2, 2, 2, 3, 4, 5, 6, 6, 6, 6, 6,
      6, 6, 6, 6, 6, 6, 6, 6};
   ckdcfg_word i_dut (.*);
   ckdcfg_host i_host (.*);
   initial forever #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cyc == 1000) give_verdict(1);
   task automatic chk(input logic [95:0] got, input logic [95:0] ex);
      total_checks++;
      if (got !== ex) err_count++;
      if (got !== ex) $display("[FAIL] %0t got %h exp %h", $time, got, ex);
   endtask
   task automatic verify();
      logic [4:0] c;
      logic [4:0] f;
      f = {cfg.ctrl_pins_25v, cfg.vco_high_range, cfg.gated_style, cfg.rising_edge,
         cfg.pll_bypass};
      chk(cfg_rdata, exp_w);
      chk(f, exp_w[61:57]);
      chk(cfg.fb_divide, exp_w[51:48]);
      for (int i = 0; i < 6; i++) begin
         c = exp_w[29 - 5 * i -: 5];
         chk(cfg.skew[5 - i].mode, skm[c]);
         chk(cfg.skew[5 - i].units, skm[c] == 1 ? 8 - c : (skm[c] == 2 ? c % 8 : 0));
         chk(cfg.drive[5 - i], exp_w[47 - 2 * i -: 2]);
         if (i < 3) chk(cfg.in_sel[2 - i], {exp_w[35 - 2 * i], ^exp_w[35 - 2 * i -: 2]});
         if (i < 5) chk(cfg.bank_state[4 - i], exp_w[56 - i] ? 1 + exp_w[59] : 0);
      end
   endtask
   initial begin
      void'($urandom(32'h6FC5));
      repeat (20) @(negedge ref_clk);
      verify();
      resetn = 1;
      for (int n = 0; n < 40; n++) begin
         w = {$urandom, $urandom, $urandom};
         w[29:25] = 5'(n);
         if (n % 2) w[57] = 0;
         i_host.write(w);
         i_host.save();
         exp_w = w & ~CKD_RSVD_MASK;
         verify();
         chk({store_go, store_refused}, exp_w[57] ? 1 : 2);
      end
      restore_data = ~w;
      restore_valid = 1;
      i_host.write(w);
      restore_valid = 0;
      exp_w = restore_data & ~CKD_RSVD_MASK;
      verify();
      clk_en = 0;
      i_host.write(w);
      i_host.save();
      clk_en = 1;
      verify();
      chk({store_go, store_refused}, 0);
      give_verdict(0);
   end
   task automatic give_verdict(input int extra);
      err_count += extra;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
endmodule
bind ckdcfg_word ckdcfg_properties i_props (.*);
